// ---- shared/rrc_pkg.sv ----
/*
 Package for the receiver reset control block: channel count, FIFO depth,
 command code and state encoding.
 Assumes a single 25 MHz system clock domain.
*/
package rrc_pkg;
	localparam int RRC_CHANNELS = 8;
	localparam int RRC_FIFO_DEPTH = 4;
	localparam int RRC_WORD_WIDTH = 32;
	localparam int RRC_LABEL_DEPTH = 16;
	localparam logic [7:0] RRC_CMD_GLOBAL_RESET = 8'h07;
	localparam int RRC_CTRL_WIDTH = 16;
	localparam int RRC_HOLD_BIT = 3;
	localparam int RRC_FILTER_BIT = 2;
	localparam logic [2:0] RRC_PTR_RESET = 3'h0;
	localparam int RRC_CLEAR_CYCLES = 16;

	typedef enum logic [2:0] {
		RRC_IDLE = 3'b001,
		RRC_GLOBAL = 3'b010,
		RRC_ERASE = 3'b100
	} rrc_phase_type;
endpackage

// ---- test/rrc_host_model.sv ----
/* Host model: command bytes and control register writes.
 Assumes callers wait for each task, all on sys_clk. */
`timescale 1ns/1ps
module rrc_host_model (
	input wire logic sys_clk,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic ctrl_wr,
	output logic [2:0] ctrl_chan,
	output logic [15:0] ctrl_data
);
	initial begin
		cmd_valid = 1'h0;
		cmd_code = 8'h00;
		ctrl_wr = 1'h0;
		ctrl_chan = 3'h0;
		ctrl_data = 16'h0000;
	end
	task automatic cmd(input logic [7:0] code);
		@(posedge sys_clk);
		cmd_valid <= 1'h1;
		cmd_code <= code;
		@(posedge sys_clk);
		cmd_valid <= 1'h0;
		cmd_code <= ~code;
	endtask
	task automatic wr(input logic [2:0] ch, input logic [15:0] d);
		@(posedge sys_clk);
		ctrl_wr <= 1'h1;
		ctrl_chan <= ch;
		ctrl_data <= d;
		@(posedge sys_clk);
		ctrl_wr <= 1'h0;
		ctrl_data <= ~d;
	endtask
endmodule

// ---- test/rrc_reset_control_properties.sv ----
/* Port checker for rrc_reset_control.
 Assumes a bind to the design, all on sys_clk. */
`timescale 1ns/1ps
module rrc_reset_control_properties
	import rrc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic global_reset_input,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic ctrl_wr,
	input wire logic [2:0] ctrl_chan,
	input wire logic [7:0] rx_abort,
	input wire logic [7:0] rx_enable,
	input wire logic [7:0] fifo_empty,
	input wire logic [7:0] fifo_full,
	input wire logic [127:0] ctrl_regs
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_gcmd;
		cmd_valid && cmd_code == RRC_CMD_GLOBAL_RESET;
	endsequence
	chk_cmd_abort: assert property (s_gcmd |=> rx_abort == 8'hFF)
		else $error("no abort");
	chk_cmd_empty: assert property (s_gcmd |=> fifo_empty == 8'hFF)
		else $error("fifo kept");
	chk_cmd_full: assert property (s_gcmd |=> fifo_full == 8'h00)
		else $error("full kept");
	chk_regs_kept: assert property (
		s_gcmd ##0 !ctrl_wr |=> $stable(ctrl_regs))
		else $error("regs changed");
	chk_wr_reset: assert property (ctrl_wr |=> fifo_empty[$past(ctrl_chan)])
		else $error("fifo kept on write");
	chk_pin_reset: assert property (
		global_reset_input [*5] |=> rx_abort == 8'hFF)
		else $error("pin ignored");
	for (genvar c = 0; c < 8; c++) begin : g_ch
		sequence s_held;
			ctrl_regs[c*16+RRC_HOLD_BIT] && $past(ctrl_regs[c*16+RRC_HOLD_BIT]);
		endsequence
		chk_hold_off: assert property (s_held |-> !rx_enable[c])
			else $error("enabled while held");
		chk_hold_empty: assert property (s_held |-> fifo_empty[c])
			else $error("fifo kept while held");
	end
endmodule

// ---- test/tb.sv ----
/* Testbench for rrc_reset_control.
 Assumes package, design, checker and host model compiled first. */
`timescale 1ns/1ps
module tb;
	import rrc_pkg::*;
	logic sys_clk = 1'h0, rstn = 1'h0, global_reset_input = 1'h0;
	logic label_wr = 1'h0, fifo_rd = 1'h0, cmd_valid, ctrl_wr, label_rd_valid;
	logic [2:0] label_chan = 3'h1, fifo_rd_chan = 3'h0, ctrl_chan;
	logic [3:0] label_addr = 4'h2;
	logic [7:0] rx_word_valid = 8'h00, cmd_code, label_rd_data;
	logic [7:0] rx_abort, rx_enable, fifo_empty, fifo_full, filt;
	logic [31:0] rx_word = 32'h0, fifo_rd_data;
	logic [15:0] ctrl_data;
	logic [127:0] ctrl_regs, regs;
	int fails = 0, check_count = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	rrc_host_model i_host (.sys_clk, .cmd_valid, .cmd_code, .ctrl_wr,
		.ctrl_chan, .ctrl_data);
	rrc_reset_control i_dut (.sys_clk, .rstn, .global_reset_input,
		.cmd_valid, .cmd_code, .ctrl_wr, .ctrl_chan, .ctrl_data, .label_wr,
		.label_chan, .label_addr, .label_data(8'h3C),
		.label_rd_addr(label_addr), .rx_busy(8'h00), .rx_word_valid,
		.rx_word, .fifo_rd, .fifo_rd_chan, .fifo_rd_data, .rx_abort,
		.rx_enable, .fifo_empty, .fifo_full, .label_filter_enable_bit(filt),
		.ctrl_regs, .label_rd_data, .label_rd_valid);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic ck(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic push(input logic [7:0] m, input logic [31:0] w);
		@(posedge sys_clk);
		rx_word_valid <= m;
		rx_word <= w;
		@(posedge sys_clk);
		rx_word_valid <= 8'h00;
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic t_fill;
		for (int i = 0; i < 4; i++) push(8'h01, 32'hA0 + i);
		chk(fifo_full, 8'h01);
		@(posedge sys_clk);
		fifo_rd <= 1'h1;
		@(posedge sys_clk);
		fifo_rd <= 1'h0;
		#1 chk(fifo_rd_data, 32'hA0);
		i_host.cmd(8'h03);
		#1 chk(fifo_empty, 8'hFE);
		push(8'h01, 32'hA4);
		chk(fifo_full, 8'h01);
		i_host.cmd(RRC_CMD_GLOBAL_RESET);
		#1 chk(rx_abort, 8'hFF);
		chk(fifo_empty, 8'hFF);
		chk(fifo_full, 8'h00);
		chk(ctrl_regs === regs, 32'h1);
		ck(2);
		chk(rx_enable, 8'hFF);
	endtask
	task automatic t_label;
		@(posedge sys_clk);
		label_wr <= 1'h1;
		@(posedge sys_clk);
		label_wr <= 1'h0;
		i_host.cmd(RRC_CMD_GLOBAL_RESET);
		ck(2);
		chk({label_rd_valid, label_rd_data}, 32'h13C);
		push(8'h03, 32'h55);
		i_host.wr(3'h1, regs[31:16]);
		ck(2);
		chk(label_rd_valid, 32'h0);
		chk(fifo_empty[1:0], 32'h2);
	endtask
	task automatic t_hold;
		push(8'h0C, 32'h66);
		i_host.wr(3'h2, 16'h000C);
		ck(1);
		chk(fifo_empty[3:2], 32'h1);
		push(8'h04, 32'h67);
		chk(fifo_empty[2], 32'h1);
		i_host.wr(3'h2, 16'h0004);
		ck(2);
		push(8'h04, 32'h68);
		chk(fifo_empty[2], 32'h0);
	endtask
	task automatic t_pin;
		@(posedge sys_clk);
		global_reset_input <= 1'h1;
		ck(6);
		chk(fifo_empty, 8'hFF);
		chk(filt, 8'h04);
		@(posedge sys_clk);
		global_reset_input <= 1'h0;
		ck(6);
		chk(rx_enable, 8'hFF);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'h1;
		for (int c = 0; c < 8; c++) begin
			regs[c*16 +: 16] = 16'hA050 | 16'(c << 8);
			i_host.wr(3'(c), regs[c*16 +: 16]);
		end
		t_fill;
		t_label;
		t_hold;
		t_pin;
		give_verdict;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			give_verdict;
		end
	end
endmodule
bind rrc_reset_control rrc_reset_control_properties i_chk (.sys_clk, .rstn,
	.global_reset_input, .cmd_valid, .cmd_code, .ctrl_wr, .ctrl_chan,
	.rx_abort, .rx_enable, .fifo_empty, .fifo_full, .ctrl_regs);

// ---- verilog/rrc_label_mem.sv ----
/*
 Label lookup memory for all channels: one write port, one registered read
 port, and a per-entry valid flag that a per-channel erase clears.
 Assumes all ports are on sys_clk.
*/
`timescale 1ns/1ps
module rrc_label_mem #(
	parameter int CHANNELS = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [$clog2(CHANNELS)-1:0] wr_chan,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [CHANNELS-1:0] erase,
	input wire logic [$clog2(CHANNELS)-1:0] rd_chan,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_valid
);
	logic [7:0] mem [CHANNELS*DEPTH];
	logic [CHANNELS*DEPTH-1:0] valid;
	localparam int AW = $clog2(CHANNELS*DEPTH);

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[{wr_chan, wr_addr}] <= wr_data;
		end
		rd_data <= mem[{rd_chan, rd_addr}];
	end

	genvar g;
	for (g = 0; g < CHANNELS*DEPTH; g++) begin : g_valid
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				valid[g] <= 1'b0;
			end else if (erase[g/DEPTH]) begin
				valid[g] <= 1'b0;
			end else if (wr_en && {wr_chan, wr_addr} == AW'(g)) begin
				valid[g] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= valid[{rd_chan, rd_addr}];
		end
	end
endmodule

// ---- verilog/rrc_reset_control.sv ----
/*
 Receiver reset control: global reset from pin or command, per-channel
 hold-in-reset, control-register writes, per-channel receive FIFOs and
 their status flags, label memory erase.
 Assumes one 25 MHz clock; the reset pin is asynchronous to it, the
 command strobe and receiver words come from logic on sys_clk.
*/
`timescale 1ns/1ps
module rrc_reset_control
	import rrc_pkg::*;
#(
	parameter int CHANNELS = rrc_pkg::RRC_CHANNELS,
	parameter int DEPTH = rrc_pkg::RRC_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic global_reset_input,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic ctrl_wr,
	input wire logic [$clog2(rrc_pkg::RRC_CHANNELS)-1:0] ctrl_chan,
	input wire logic [rrc_pkg::RRC_CTRL_WIDTH-1:0] ctrl_data,
	input wire logic label_wr,
	input wire logic [$clog2(rrc_pkg::RRC_CHANNELS)-1:0] label_chan,
	input wire logic [3:0] label_addr,
	input wire logic [7:0] label_data,
	input wire logic [3:0] label_rd_addr,
	input wire logic [rrc_pkg::RRC_CHANNELS-1:0] rx_busy,
	input wire logic [rrc_pkg::RRC_CHANNELS-1:0] rx_word_valid,
	input wire logic [rrc_pkg::RRC_WORD_WIDTH-1:0] rx_word,
	input wire logic fifo_rd,
	input wire logic [$clog2(rrc_pkg::RRC_CHANNELS)-1:0] fifo_rd_chan,
	output logic [rrc_pkg::RRC_WORD_WIDTH-1:0] fifo_rd_data,
	output logic [rrc_pkg::RRC_CHANNELS-1:0] rx_abort,
	output logic [rrc_pkg::RRC_CHANNELS-1:0] rx_enable,
	output logic [rrc_pkg::RRC_CHANNELS-1:0] fifo_empty,
	output logic [rrc_pkg::RRC_CHANNELS-1:0] fifo_full,
	output logic [rrc_pkg::RRC_CHANNELS-1:0] label_filter_enable_bit,
	output logic [rrc_pkg::RRC_CTRL_WIDTH*rrc_pkg::RRC_CHANNELS-1:0] ctrl_regs,
	output logic [7:0] label_rd_data,
	output logic label_rd_valid
);
	import rrc_pkg::*;
	localparam int CW = $clog2(CHANNELS);
	localparam int PW = $clog2(DEPTH) + 1;

	typedef struct packed {
		logic [2:0] pin_sync;
		logic pin_level;
		logic [CHANNELS*DEPTH*RRC_WORD_WIDTH-1:0] fifo;
		logic [CHANNELS*PW-1:0] count;
		logic [RRC_CTRL_WIDTH*CHANNELS-1:0] ctrl;
		logic [CHANNELS-1:0] abort;
		logic [CHANNELS-1:0] enable;
		logic [CHANNELS-1:0] empty;
		logic [CHANNELS-1:0] full;
		logic [CHANNELS-1:0] filter;
		logic [RRC_WORD_WIDTH-1:0] rd_data;
		rrc_phase_type phase;
	} rrc_state_type;

	rrc_state_type state;
	rrc_state_type next_state;
	logic [CHANNELS-1:0] erase;

	// The written channel's label memory is erased on every control write, never by global reset
	always_comb begin
		erase = '0;
		if (ctrl_wr) begin
			erase[ctrl_chan] = 1'b1;
		end
	end

	rrc_label_mem #(
		.CHANNELS(CHANNELS),
		.DEPTH(RRC_LABEL_DEPTH)
	) u_label_mem (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.wr_en(label_wr),
		.wr_chan(label_chan),
		.wr_addr(label_addr),
		.wr_data(label_data),
		.erase(erase),
		.rd_chan(label_chan),
		.rd_addr(label_rd_addr),
		.rd_data(label_rd_data),
		.rd_valid(label_rd_valid)
	);

	always_comb begin
		logic global_req;
		logic [CHANNELS-1:0] chan_clear;
		logic [PW-1:0] cnt;
		logic hold;
		global_req = 1'b0;
		chan_clear = '0;
		cnt = '0;
		hold = 1'b0;
		next_state = state;
		next_state.pin_sync = {state.pin_sync[1:0], global_reset_input};
		// Pin level moves only once the last two sync stages agree
		if (state.pin_sync[1] == state.pin_sync[2]) begin
			next_state.pin_level = state.pin_sync[2];
		end
		global_req = state.pin_level
			| (cmd_valid && cmd_code == RRC_CMD_GLOBAL_RESET);
		case (state.phase)
			RRC_IDLE: begin
				if (global_req) begin
					next_state.phase = RRC_GLOBAL;
				end else if (ctrl_wr) begin
					next_state.phase = RRC_ERASE;
				end
			end
			RRC_GLOBAL: begin
				if (!global_req) begin
					next_state.phase = RRC_IDLE;
				end
			end
			RRC_ERASE: begin
				next_state.phase = RRC_IDLE;
			end
			default: begin
				next_state.phase = RRC_IDLE;
			end
		endcase
		// Control registers are untouched by global reset
		if (ctrl_wr) begin
			next_state.ctrl[ctrl_chan*RRC_CTRL_WIDTH +: RRC_CTRL_WIDTH]
				= ctrl_data;
		end
		next_state.rd_data = state.rd_data;
		for (int c = 0; c < CHANNELS; c++) begin
			hold = state.ctrl[c*RRC_CTRL_WIDTH + RRC_HOLD_BIT];
			if (ctrl_wr && ctrl_chan == CW'(c)) begin
				hold = ctrl_data[RRC_HOLD_BIT];
				chan_clear[c] = 1'b1;
			end
			chan_clear[c] = chan_clear[c] | hold | global_req;
			next_state.filter[c] =
				next_state.ctrl[c*RRC_CTRL_WIDTH + RRC_FILTER_BIT];
			next_state.abort[c] = chan_clear[c];
			next_state.enable[c] = !chan_clear[c];
			cnt = state.count[c*PW +: PW];
			if (chan_clear[c]) begin
				cnt = '0;
			end else begin
				if (fifo_rd && fifo_rd_chan == CW'(c) && cnt != '0) begin
					for (int k = 0; k < DEPTH - 1; k++) begin
						next_state.fifo[(c*DEPTH+k)*RRC_WORD_WIDTH +:
							RRC_WORD_WIDTH] = state.fifo[(c*DEPTH+k+1)*
							RRC_WORD_WIDTH +: RRC_WORD_WIDTH];
					end
					cnt = cnt - PW'(1);
				end
				if (rx_word_valid[c] && state.enable[c]) begin
					// A full FIFO overwrites its newest word
					if (cnt == PW'(DEPTH)) begin
						cnt = cnt - PW'(1);
					end
					next_state.fifo[(c*DEPTH)*RRC_WORD_WIDTH +
						int'(cnt)*RRC_WORD_WIDTH +: RRC_WORD_WIDTH] = rx_word;
					cnt = cnt + PW'(1);
				end
			end
			next_state.count[c*PW +: PW] = cnt;
			next_state.empty[c] = (cnt == '0);
			next_state.full[c] = (cnt == PW'(DEPTH));
		end
		// Reading an empty FIFO returns whatever the head slot holds
		next_state.rd_data = state.fifo[int'(fifo_rd_chan)*DEPTH*
			RRC_WORD_WIDTH +: RRC_WORD_WIDTH];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
			state.phase <= RRC_IDLE;
			state.empty <= '1;
			state.abort <= '1;
		end else begin
			state <= next_state;
		end
	end

	assign fifo_rd_data = state.rd_data;
	assign rx_abort = state.abort;
	assign rx_enable = state.enable;
	assign fifo_empty = state.empty;
	assign fifo_full = state.full;
	assign label_filter_enable_bit = state.filter;
	assign ctrl_regs = state.ctrl;
endmodule
